//--- sssw_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module sssw_cpu_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    output logic kick,
    output logic driven
);
    logic [5:0] tick = 6'h00;
    logic kick_q = 1'b0;
    logic driven_q = 1'b0;
    assign kick = kick_q;
    assign driven = driven_q;
    // free phase counter; a 7-cycle pulse (56 ns) every 40 cycles keeps near the shortest kick
    always @(posedge clk) begin
        tick <= (tick == 6'h27) ? 6'h00 : tick + 6'h01;
    end
    // mode 0 floats the line, so it wanders; mode 1 holds it; mode 2 kicks while out of reset
    always @(posedge clk) begin
        driven_q <= #1 (mode != 2'h0);
        if (mode == 2'h0) kick_q <= #1 !kick_q;
        else if (mode == 2'h2 && rst_n) kick_q <= #1 (tick < 6'h07);
    end
endmodule
`default_nettype wire

//--- sssw_pkg.sv
package sssw_pkg;

    // ------------------------------------------------------------------
    // timebase and documented times
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 125_000_000;
    localparam int unsigned CLK_PER_MS = CLK_FREQ_HZ / 1000;
    localparam int unsigned RESET_PULSE_MS = 200;
    localparam int unsigned EXTEND_PULSE_MS = 100;
    localparam int unsigned WD_TIMEOUT_MS = 1600;

    // exact multiples of the clock period, so no rounding is needed
    localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_MS * CLK_PER_MS;
    localparam int unsigned EXTEND_PULSE_CYCLES = EXTEND_PULSE_MS * CLK_PER_MS;
    localparam int unsigned WD_TIMEOUT_CYCLES = WD_TIMEOUT_MS * CLK_PER_MS;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W = 28;
    localparam logic SUPPLY_LOW_RST = 1'b1;
    localparam logic MANUAL_N_RST = 1'b1;
    localparam logic KICK_RST = 1'b0;
    localparam logic DRIVEN_RST = 1'b0;

    // which event most recently started or prolonged a reset pulse
    typedef struct packed {
        logic supply_low;
        logic manual;
        logic watchdog;
    } sssw_cause_t;

    localparam sssw_cause_t CAUSE_RST = '{supply_low: 1'b1, manual: 1'b0, watchdog: 1'b0};

endpackage

//--- sssw_props.sv
`timescale 1ns/10ps
`default_nettype none
module sssw_props #(
    parameter int unsigned RESET_CYCLES = 20,
    parameter int unsigned WD_CYCLES = 50
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic supply_low_input,
    input wire logic manual_reset_n_input,
    input wire logic watchdog_kick_input,
    input wire logic watchdog_kick_driven,
    input wire logic reset_n_output,
    input wire sssw_pkg::sssw_cause_t reset_cause
);
    int unsigned low_run;
    int unsigned idle;
    // ------------------------------------------------------------------
    // helper counts
    // ------------------------------------------------------------------
    // length of the current low stretch of the reset output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) low_run <= 0;
        else low_run <= reset_n_output ? 0 : low_run + 1;
    end
    // cycles with the output high, the kick line driven and no toggle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) idle <= 0;
        else if (!reset_n_output || !watchdog_kick_driven || $changed(watchdog_kick_input)) idle <= 0;
        else idle <= idle + 1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // a low-supply step that has passed the synchroniser
    sequence brown_s;
        $rose(supply_low_input) ##1 supply_low_input[*4];
    endsequence
    low_hold_a: assert property (supply_low_input[*6] |-> !reset_n_output)
        else $error("reset high under low supply");
    supply_fast_a: assert property (brown_s |-> ##1 !reset_n_output)
        else $error("low supply not forcing reset");
    pulse_len_a: assert property ($rose(reset_n_output) |-> low_run >= RESET_CYCLES)
        else $error("reset pulse too short");
    extend_len_a: assert property ($fell(supply_low_input) && !reset_n_output |-> ##6 (!reset_n_output)[*8])
        else $error("pulse not extended after brownout");
    manual_hold_a: assert property ((!manual_reset_n_input)[*6] |-> !reset_n_output)
        else $error("manual reset ignored");
    wd_bound_a: assert property (idle <= WD_CYCLES + 8)
        else $error("watchdog did not expire in time");
    wd_early_a: assert property ($fell(reset_n_output) && !$past(supply_low_input, 2) && $past(manual_reset_n_input, 2) |-> idle >= WD_CYCLES)
        else $error("watchdog expired early");
    float_quiet_a: assert property ($fell(reset_n_output) |-> $past(watchdog_kick_driven, 2) || $past(supply_low_input, 2) || !$past(manual_reset_n_input, 2))
        else $error("watchdog ran while kick line floated");
endmodule
`default_nettype wire

//--- sssw_sync.sv
`timescale 1ns/10ps
`default_nettype none

// three-stage synchroniser; the output moves only when stages two and three agree
module sssw_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic async_in,
    output logic sync_out
);

    logic ff1;
    logic ff2;
    logic ff3;

    // ------------------------------------------------------------------
    // capture chain
    // ------------------------------------------------------------------
    // ff1 feeds ff2 only, so metastability never reaches the compare
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ff1 <= RST_VAL;
            ff2 <= RST_VAL;
            ff3 <= RST_VAL;
        end else begin
            ff1 <= async_in;
            ff2 <= ff1;
            ff3 <= ff2;
        end
    end

    // agreement filter, registered so the output is a clean flop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync_out <= RST_VAL;
        end else if (ff2 == ff3) begin
            sync_out <= ff3;
        end
    end

endmodule

`default_nettype wire

//--- sssw_top.sv
// What this block does
// - after supply recovers, reset output stays low for a 200 ms timed pulse.
// - reset output goes low and stays low while supply is below threshold.
// - a brownout during a pulse extends reset by at least another 100 ms.
// - watchdog not toggled within 1.6 s while driven forces a reset pulse.
// - watchdog counter held cleared while reset is low or kick input floats.
// - watchdog counting starts right after reset release when kick input is driven.
// - any kick toggle restarts the count; 50 ns kicks are still seen.
// - low supply forces reset regardless of the watchdog state.
// - low manual reset input starts a reset pulse.
`timescale 1ns/10ps
`default_nettype none

module sssw_top #(
    parameter int unsigned RESET_CYCLES = sssw_pkg::RESET_PULSE_CYCLES,
    parameter int unsigned EXTEND_CYCLES = sssw_pkg::EXTEND_PULSE_CYCLES,
    parameter int unsigned WD_CYCLES = sssw_pkg::WD_TIMEOUT_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic supply_low_input,
    input wire logic manual_reset_n_input,
    input wire logic watchdog_kick_input,
    input wire logic watchdog_kick_driven,
    output logic reset_n_output,
    output sssw_pkg::sssw_cause_t reset_cause
);

    localparam int unsigned W = sssw_pkg::CNT_W;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_PULSE,
        ST_RUN
    } sssw_state_t;

    sssw_state_t state;
    logic [W-1:0] pulse_cnt;
    logic [W-1:0] wd_cnt;
    logic supply_low;
    logic manual_n;
    logic kick;
    logic kick_prev;
    logic driven;
    logic kicked;
    logic wd_expire;

    // larger of two counts; keeps a pulse from ever being shortened
    function automatic logic [W-1:0] at_least(input logic [W-1:0] a, input logic [W-1:0] b);
        at_least = (a > b) ? a : b;
    endfunction

    // one cause word per event that starts or prolongs a pulse; the fields are exclusive by construction,
    // so a status reader never sees two causes at once
    function automatic sssw_pkg::sssw_cause_t cause_word(input logic low, input logic man,
        input logic wd);
        cause_word = '{supply_low: low, manual: man, watchdog: wd};
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // comparator output is asynchronous to the timebase
    sssw_sync #(.RST_VAL(sssw_pkg::SUPPLY_LOW_RST)) u_sync_supply (
        .clk(clk),
        .resetn(resetn),
        .async_in(supply_low_input),
        .sync_out(supply_low)
    );

    sssw_sync #(.RST_VAL(sssw_pkg::MANUAL_N_RST)) u_sync_manual (
        .clk(clk),
        .resetn(resetn),
        .async_in(manual_reset_n_input),
        .sync_out(manual_n)
    );

    // 50 ns is over six clocks, enough for the agreement filter
    sssw_sync #(.RST_VAL(sssw_pkg::KICK_RST)) u_sync_kick (
        .clk(clk),
        .resetn(resetn),
        .async_in(watchdog_kick_input),
        .sync_out(kick)
    );

    sssw_sync #(.RST_VAL(sssw_pkg::DRIVEN_RST)) u_sync_driven (
        .clk(clk),
        .resetn(resetn),
        .async_in(watchdog_kick_driven),
        .sync_out(driven)
    );

    // ------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------
    assign kicked = (kick != kick_prev);
    assign wd_expire = reset_n_output && driven && !kicked
        && (wd_cnt == W'(WD_CYCLES - 1));

    // edge memory for kick detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            kick_prev <= sssw_pkg::KICK_RST;
        end else begin
            kick_prev <= kick;
        end
    end

    // counter saturates at the timeout; the state machine reacts next edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wd_cnt <= '0;
        end else if (!reset_n_output || !driven) begin
            wd_cnt <= '0;
        end else if (kicked) begin
            wd_cnt <= '0;
        end else if (wd_cnt != W'(WD_CYCLES - 1)) begin
            wd_cnt <= wd_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    // low supply is checked first in every state, so it always wins;
    // the pulse timer and the cause word below follow the same priority
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_HOLD;
            reset_n_output <= 1'b0;
        end else begin
            case (state)
                ST_HOLD: begin
                    reset_n_output <= 1'b0;
                    if (!supply_low) begin
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    reset_n_output <= 1'b0;
                    if (supply_low) begin
                        state <= ST_HOLD;
                    end else if (manual_n && (pulse_cnt == '0)) begin
                        state <= ST_RUN;
                        reset_n_output <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (supply_low) begin
                        state <= ST_HOLD;
                        reset_n_output <= 1'b0;
                    end else if (!manual_n) begin
                        state <= ST_PULSE;
                        reset_n_output <= 1'b0;
                    end else if (wd_expire) begin
                        state <= ST_PULSE;
                        reset_n_output <= 1'b0;
                    end
                end
                default: begin
                    state <= ST_HOLD;
                    reset_n_output <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pulse timer
    // ------------------------------------------------------------------
    // loaded on every way into a pulse and counted down to zero; while the
    // supply is low the value is left alone, since recovery reloads it anyway
    // limitation: a held button keeps the count at a full pulse, so a stuck button means
    // a reset that never ends
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pulse_cnt <= '0;
        end else begin
            case (state)
                ST_HOLD: begin
                    if (!supply_low) begin
                        // recovery length never under the extension
                        pulse_cnt <= at_least(W'(RESET_CYCLES - 1), W'(EXTEND_CYCLES - 1));
                    end
                end
                ST_PULSE: begin
                    if (!supply_low && !manual_n) begin
                        // button held: pulse restarts, never shortens
                        pulse_cnt <= at_least(pulse_cnt, W'(RESET_CYCLES - 1));
                    end else if (!supply_low && (pulse_cnt != '0)) begin
                        pulse_cnt <= pulse_cnt - 1'b1;
                    end
                end
                ST_RUN: begin
                    // a full pulse for a button or an expiry; a brownout loads in hold
                    if (!supply_low && (!manual_n || wd_expire)) begin
                        pulse_cnt <= W'(RESET_CYCLES - 1);
                    end
                end
                default: begin
                    pulse_cnt <= '0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // reset cause
    // ------------------------------------------------------------------
    // kept after release so the processor can tell why it was reset;
    // hold has nothing to add, as every way into it has already said supply
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reset_cause <= sssw_pkg::CAUSE_RST;
        end else if ((state == ST_PULSE) || (state == ST_RUN)) begin
            if (supply_low) begin
                reset_cause <= cause_word(1'b1, 1'b0, 1'b0);
            end else if (!manual_n) begin
                reset_cause <= cause_word(1'b0, 1'b1, 1'b0);
            end else if ((state == ST_RUN) && wd_expire) begin
                reset_cause <= cause_word(1'b0, 1'b0, 1'b1);
            end
        end
    end

endmodule

`default_nettype wire

//--- supply_supervisor_watchdog_reset_tb.sv
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_watchdog_reset_tb;
    localparam int unsigned RST_C = 20;
    localparam int unsigned WD_C = 50;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic supply_low = 1'b1;
    logic manual_n = 1'b1;
    logic [1:0] mode = 2'h1;
    logic kick;
    logic driven;
    logic rst_out;
    sssw_pkg::sssw_cause_t cause;
    int err_total = 0;
    int n_compared = 0;
    int n;
    always #4 clk = ~clk;
    sssw_top #(.RESET_CYCLES(RST_C), .EXTEND_CYCLES(10), .WD_CYCLES(WD_C)) dut (.clk(clk),
        .resetn(resetn), .supply_low_input(supply_low), .manual_reset_n_input(manual_n),
        .watchdog_kick_input(kick), .watchdog_kick_driven(driven), .reset_n_output(rst_out),
        .reset_cause(cause));
    sssw_cpu_model cpu (.clk(clk), .rst_n(rst_out), .mode(mode), .kick(kick), .driven(driven));
    task automatic summarize;
        if (err_total == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic chk_in(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask
    // inputs always move 1 ns after the edge
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_lvl(input logic lvl, output int c);
        c = 0;
        while (rst_out !== lvl && c < 1000) begin
            step(1);
            c++;
        end
    endtask
    task automatic t_powerup;
        supply_low = 1'b0;
        wait_lvl(1'b1, n);
        chk_in("power-up pulse", RST_C, RST_C + 8, n);
        chk("power-up cause", 32'h4, cause);
    endtask
    task automatic t_kick;
        mode = 2'h2;
        n = 0;
        repeat (300) begin
            step(1);
            if (rst_out !== 1'b1) n++;
        end
        chk("low cycles while kicked", 32'h0, n);
    endtask
    task automatic t_expire;
        mode = 2'h1;
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        chk_in("watchdog pulse", RST_C, RST_C + 2, n);
        wait_lvl(1'b0, n);
        chk_in("timeout after release", WD_C, WD_C + 4, n);
        chk("watchdog cause", 32'h1, cause);
        // outside logic feeds the falling output back as a short manual pulse
        manual_n = 1'b0;
        step(6);
        manual_n = 1'b1;
        wait_lvl(1'b1, n);
        chk_in("looped pulse", RST_C, RST_C + 8, n);
        chk("looped cause", 32'h2, cause);
    endtask
    // brownout straight out of normal running
    task automatic t_drop;
        supply_low = 1'b1;
        wait_lvl(1'b0, n);
        chk_in("brownout response", 1, 6, n);
        chk("run brownout cause", 32'h4, cause);
        supply_low = 1'b0;
        wait_lvl(1'b1, n);
        chk_in("recovery pulse", RST_C, RST_C + 8, n);
    endtask
    task automatic t_float;
        mode = 2'h0;
        n = 0;
        repeat (200) begin
            step(1);
            if (rst_out !== 1'b1) n++;
        end
        chk("low cycles while floating", 32'h0, n);
        mode = 2'h1;
        wait_lvl(1'b0, n);
        chk_in("timeout after float", WD_C, WD_C + 8, n);
        wait_lvl(1'b1, n);
    endtask
    task automatic t_manual;
        manual_n = 1'b0;
        wait_lvl(1'b0, n);
        chk_in("manual response", 1, 6, n);
        step(30);
        chk("output under manual", 32'h0, rst_out);
        manual_n = 1'b1;
        wait_lvl(1'b1, n);
        chk_in("manual pulse", RST_C, RST_C + 8, n);
        chk("manual cause", 32'h2, cause);
    endtask
    task automatic t_brown;
        manual_n = 1'b0;
        step(8);
        manual_n = 1'b1;
        step(5);
        supply_low = 1'b1;
        step(30);
        chk("output in brownout", 32'h0, rst_out);
        supply_low = 1'b0;
        wait_lvl(1'b1, n);
        chk_in("extended pulse", 10, RST_C + 8, n);
        chk("brownout cause", 32'h4, cause);
    endtask
    // whole run is about a thousand cycles; the limit is about twenty times that
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial begin
        step(10);
        resetn = 1'b1;
        t_powerup();
        t_kick();
        t_expire();
        t_drop();
        t_float();
        t_manual();
        t_brown();
        summarize();
    end
endmodule
bind sssw_top sssw_props #(.RESET_CYCLES(RESET_CYCLES), .WD_CYCLES(WD_CYCLES)) props (.clk(clk),
    .resetn(resetn), .supply_low_input(supply_low_input),
    .manual_reset_n_input(manual_reset_n_input), .watchdog_kick_input(watchdog_kick_input),
    .watchdog_kick_driven(watchdog_kick_driven), .reset_n_output(reset_n_output),
    .reset_cause(reset_cause));
`default_nettype wire
